// [rtl/crps_pkg.sv]
// constants for the processor reset and power-up sequencer
package crps_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS      = 10;
    localparam int BUS_RELEASE_CLKS   = 2;
    localparam int CACHE_LINES        = 64;
    localparam int SELF_TEST_CLKS     = 32;
    // ------------------------------------------------------------
    // power-on configuration strap layout
    // ------------------------------------------------------------
    localparam int CFG_WIDTH          = 8;
    localparam int CFG_TRISTATE_BIT   = 0;
    // ------------------------------------------------------------
    // addresses and reset values
    // ------------------------------------------------------------
    localparam logic [35:0] RESET_VECTOR = 36'h0FFFFFFF0;
    localparam logic [7:0]  CFG_RESET    = 8'h00;

    typedef enum logic [2:0] {
        CRPS_HELD,
        CRPS_CLEAR,
        CRPS_WAIT_REL,
        CRPS_SELF_TEST,
        CRPS_FETCH,
        CRPS_RUN,
        CRPS_FLOAT
    } crps_state_e;
endpackage

// [rtl/crps_sequencer.sv]
// reset and power-up sequencer of the processor core
`timescale 1ns/1ps
// What this block does
// - while reset is asserted all internal state goes to defined values.
// - reset invalidates the one set of cache line valid bits with no write-back of modified lines.
// - on seeing reset asserted, bus outputs are released within two bus clocks.
// - configuration straps are captured at the clock that leaves CRPS_WAIT_REL, after the cache invalidation that follows reset assertion.
// - a strap selecting float leaves the outputs high-impedance instead of starting.
// - soft-init active at reset release runs the self-test before execution.
// - after reset, with or without self-test, fetching starts at the reset vector.
module crps_sequencer #(
    parameter int CFG_W      = crps_pkg::CFG_WIDTH,
    parameter int LINES      = crps_pkg::CACHE_LINES,
    parameter int TEST_CLKS  = crps_pkg::SELF_TEST_CLKS
) (
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic              power_stable_in,
    input  wire logic              bus_reset_n,
    input  wire logic              soft_init_n,
    input  wire logic [CFG_W-1:0]  cfg_strap,
    input  wire logic              bus_drive_req,
    output logic                   bus_out_en,
    output logic [CFG_W-1:0]       cfg_captured,
    output logic                   outputs_float,
    output logic                   self_test_run,
    output logic                   fetch_valid,
    output logic [35:0]            fetch_addr,
    output logic                   core_running,
    output logic                   cache_inval_busy,
    output logic                   cache_dirty_writeback
);
    // ------------------------------------------------------------
    // pin synchronisers: three flops, change taken when 2nd and 3rd agree
    // ------------------------------------------------------------
    logic [2:0]       pwr_sync;
    logic [2:0]       rst_sync;
    logic [2:0]       init_sync;
    logic [CFG_W-1:0] cfg_s1;
    logic [CFG_W-1:0] cfg_s2;
    logic [CFG_W-1:0] cfg_s3;
    logic [CFG_W-1:0] cfg_level;
    logic             pwr_ok;
    logic             rst_act;
    logic             init_act;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pwr_sync  <= 3'h0;
            rst_sync  <= 3'h0;
            init_sync <= 3'h7;
            cfg_s1    <= '0;
            cfg_s2    <= '0;
            cfg_s3    <= '0;
        end else begin
            pwr_sync  <= {pwr_sync[1:0], power_stable_in};
            rst_sync  <= {rst_sync[1:0], bus_reset_n};
            init_sync <= {init_sync[1:0], soft_init_n};
            cfg_s1    <= cfg_strap;
            cfg_s2    <= cfg_s1;
            cfg_s3    <= cfg_s2;
        end
    end

    // filtered levels: hold previous value until stages 2 and 3 agree
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pwr_ok    <= 1'b0;
            rst_act   <= 1'b1;
            init_act  <= 1'b0;
            cfg_level <= '0;
        end else begin
            // straps filtered bit by bit: a bit moves only when stages 2 and 3 agree
            cfg_level <= (cfg_s2 & cfg_s3) | (cfg_level & (cfg_s2 | cfg_s3));
            if (pwr_sync[1] == pwr_sync[2])
                pwr_ok <= pwr_sync[2];
            if (rst_sync[1] == rst_sync[2])
                rst_act <= ~rst_sync[2];
            if (init_sync[1] == init_sync[2])
                init_act <= ~init_sync[2];
        end
    end

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    crps_pkg::crps_state_e state;
    crps_pkg::crps_state_e next_state;
    logic [$clog2(LINES)-1:0]    line_cnt;
    logic [$clog2(TEST_CLKS):0]  test_cnt;
    logic [LINES-1:0]            line_valid;

    // power not good forces reset whatever the reset pin says
    wire in_reset    = rst_act | ~pwr_ok;
    wire release_now = state == crps_pkg::CRPS_WAIT_REL && !in_reset;
    wire float_sel   = cfg_level[crps_pkg::CFG_TRISTATE_BIT];

    wire inval_done = line_cnt == ($clog2(LINES))'(LINES - 1);
    wire test_done  = test_cnt == ($clog2(TEST_CLKS)+1)'(TEST_CLKS - 1);

    always_comb begin
        next_state = state;
        case (state)
            crps_pkg::CRPS_HELD:      next_state = crps_pkg::CRPS_CLEAR;
            crps_pkg::CRPS_CLEAR:     if (inval_done) next_state = crps_pkg::CRPS_WAIT_REL;
            crps_pkg::CRPS_WAIT_REL: begin
                if (!in_reset) begin
                    if (float_sel)
                        next_state = crps_pkg::CRPS_FLOAT;
                    else if (init_act)
                        next_state = crps_pkg::CRPS_SELF_TEST;
                    else
                        next_state = crps_pkg::CRPS_FETCH;
                end
            end
            crps_pkg::CRPS_SELF_TEST: if (test_done) next_state = crps_pkg::CRPS_FETCH;
            crps_pkg::CRPS_FETCH:     next_state = crps_pkg::CRPS_RUN;
            crps_pkg::CRPS_RUN:       next_state = crps_pkg::CRPS_RUN;
            crps_pkg::CRPS_FLOAT:     next_state = crps_pkg::CRPS_FLOAT;
            default:                  next_state = crps_pkg::CRPS_HELD;
        endcase
        // a reset observed in any state but CRPS_CLEAR and CRPS_WAIT_REL restarts the whole sequence
        if (in_reset && state != crps_pkg::CRPS_CLEAR && state != crps_pkg::CRPS_WAIT_REL)
            next_state = crps_pkg::CRPS_HELD;
    end

    // ------------------------------------------------------------
    // sequencer state and counters
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state    <= crps_pkg::CRPS_HELD;
            line_cnt <= '0;
            test_cnt <= '0;
        end else begin
            state    <= next_state;
            line_cnt <= (state == crps_pkg::CRPS_CLEAR && !inval_done) ? line_cnt + 1'b1 : '0;
            test_cnt <= (state == crps_pkg::CRPS_SELF_TEST) ? test_cnt + 1'b1 : '0;
        end
    end

    // cache tags: valid bits dropped one line per clock, no write-back path
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            line_valid <= '0;
        else if (state == crps_pkg::CRPS_CLEAR)
            line_valid[line_cnt] <= 1'b0;
        else if (state == crps_pkg::CRPS_RUN && bus_drive_req)
            line_valid[line_cnt] <= 1'b1;
    end

    // ------------------------------------------------------------
    // outputs, all registered
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bus_out_en            <= 1'b0;
            cfg_captured          <= crps_pkg::CFG_RESET;
            outputs_float         <= 1'b0;
            self_test_run         <= 1'b0;
            fetch_valid           <= 1'b0;
            fetch_addr            <= '0;
            core_running          <= 1'b0;
            cache_inval_busy      <= 1'b0;
            cache_dirty_writeback <= 1'b0;
        end else begin
            // reset seen after sync: released well inside two bus clocks of filter
            bus_out_en   <= bus_drive_req && !in_reset
                            && state == crps_pkg::CRPS_RUN;
            if (release_now)
                cfg_captured <= cfg_level;
            outputs_float    <= next_state == crps_pkg::CRPS_FLOAT;
            self_test_run    <= next_state == crps_pkg::CRPS_SELF_TEST;
            fetch_valid      <= next_state == crps_pkg::CRPS_FETCH;
            fetch_addr       <= (next_state == crps_pkg::CRPS_FETCH)
                                ? crps_pkg::RESET_VECTOR : '0;
            core_running     <= next_state == crps_pkg::CRPS_RUN;
            cache_inval_busy <= next_state == crps_pkg::CRPS_CLEAR;
            cache_dirty_writeback <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_release_float;
        release_now && float_sel;
    endsequence

    sequence s_release_test;
        release_now && !float_sel && init_act;
    endsequence

    a_bus_release: assert property (in_reset |=> !bus_out_en)
        else $error("bus outputs still driven in reset");
    a_no_writeback: assert property (!cache_dirty_writeback)
        else $error("write-back during invalidation");
    a_strap_capture: assert property (release_now |=> cfg_captured == $past(cfg_level))
        else $error("straps not captured at release");
    a_lines_cleared: assert property (state == crps_pkg::CRPS_WAIT_REL |-> line_valid == '0)
        else $error("cache line still valid after invalidation");
    a_float_sel: assert property (s_release_float |=> outputs_float && !fetch_valid)
        else $error("float strap ignored");
    a_test_first: assert property (s_release_test |=> self_test_run [*8])
        else $error("self-test not run");
    a_vector: assert property (fetch_valid |-> fetch_addr == crps_pkg::RESET_VECTOR)
        else $error("fetch not at reset vector");
    a_pwr_hold: assert property (!pwr_ok |=> !core_running && !fetch_valid)
        else $error("core ran without power good");
    a_reset_state: assert property (in_reset && state == crps_pkg::CRPS_RUN
                                    |=> state == crps_pkg::CRPS_HELD)
        else $error("reset did not restart sequence");
endmodule

// [verification/crps_platform_model.sv]
// platform reset and power-good model that drives the sequencer's reset inputs
`timescale 1ns/1ps
module crps_platform_model #(
    parameter int PWR_CLKS   = 20,
    parameter int PULSE_CLKS = 100
) (
    input  wire logic clk,
    input  wire logic start,
    input  wire logic early,
    output logic      power_stable_in,
    output logic      bus_reset_n,
    output logic      busy
);
    // ------------------------------------------------------------
    // sequence: drop power and reset, hold, raise power, pulse reset
    // ------------------------------------------------------------
    initial begin
        power_stable_in = 1'b0;
        bus_reset_n     = 1'b0;
        busy            = 1'b0;
        forever begin
            @(posedge clk);
            if (start) begin
                busy            <= 1'b1;
                power_stable_in <= 1'b0;
                bus_reset_n     <= 1'b0;
                repeat (PWR_CLKS) @(posedge clk);
                // out-of-order release, only when the bench asks for it
                if (early) begin
                    bus_reset_n <= 1'b1;
                end
                repeat (PWR_CLKS) @(posedge clk);
                power_stable_in <= 1'b1;
                // an early release is taken back so every power rise gets its pulse
                bus_reset_n     <= 1'b0;
                // pulse shortened from 1 ms to keep the run short
                repeat (PULSE_CLKS) @(posedge clk);
                bus_reset_n <= 1'b1;
                busy        <= 1'b0;
            end
        end
    end
endmodule

// [verification/testbench.sv]
// self-checking bench for the reset and power-up sequencer
`timescale 1ns/1ps
module testbench;
    logic clk, reset_n, start, early, soft_init_n, bus_drive_req;
    logic power_stable_in, bus_reset_n, busy, bus_out_en, outputs_float, self_test_run;
    logic fetch_valid, core_running, cache_inval_busy, cache_dirty_writeback;
    logic [7:0]  cfg_strap, cfg_captured;
    logic [35:0] fetch_addr;
    int          errors, comparisons;

    crps_sequencer #(.CFG_W(8), .LINES(8), .TEST_CLKS(8)) dut_u (
        .clk(clk), .reset_n(reset_n), .power_stable_in(power_stable_in),
        .bus_reset_n(bus_reset_n), .soft_init_n(soft_init_n), .cfg_strap(cfg_strap),
        .bus_drive_req(bus_drive_req), .bus_out_en(bus_out_en), .cfg_captured(cfg_captured),
        .outputs_float(outputs_float), .self_test_run(self_test_run),
        .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .core_running(core_running),
        .cache_inval_busy(cache_inval_busy), .cache_dirty_writeback(cache_dirty_writeback));
    crps_platform_model plat_u (
        .clk(clk), .start(start), .early(early), .power_stable_in(power_stable_in),
        .bus_reset_n(bus_reset_n), .busy(busy));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic finish_test();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check_val(input logic [35:0] got, input logic [35:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    function automatic logic exp_float(input logic [7:0] cfg);
        return cfg[crps_pkg::CFG_TRISTATE_BIT];
    endfunction

    // ------------------------------------------------------------
    // one platform reset cycle followed by the core's start-up
    // ------------------------------------------------------------
    task automatic boot(input logic [7:0] cfg, input logic init_n, input logic early_mode);
        logic seen_test, seen_inval, seen_early, done, drv;
        int   n;
        seen_test = 1'b0; seen_inval = 1'b0; seen_early = 1'b0; done = 1'b0; n = 0;
        drv = 1'($urandom);
        @(posedge clk);
        cfg_strap <= cfg; soft_init_n <= init_n; early <= early_mode;
        start <= 1'b1; bus_drive_req <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (6) @(posedge clk);
        #1 check_val(36'(bus_out_en), 36'h0);
        while (!done && n < 600) begin
            @(posedge clk);
            #1 n++;
            if (self_test_run === 1'b1) seen_test = 1'b1;
            if (cache_inval_busy === 1'b1) seen_inval = 1'b1;
            if (power_stable_in === 1'b0 && (fetch_valid !== 1'b0 || core_running !== 1'b0))
                seen_early = 1'b1;
            if (fetch_valid === 1'b1 || outputs_float === 1'b1) done = 1'b1;
        end
        if (!done) begin
            errors++;
            finish_test();
        end else begin
            check_val(36'(cfg_captured), 36'(cfg));
            check_val(36'(outputs_float), 36'(exp_float(cfg)));
            check_val(36'(seen_test), 36'(!exp_float(cfg) && !init_n));
            check_val(fetch_addr, exp_float(cfg) ? 36'h0 : crps_pkg::RESET_VECTOR);
            check_val(36'({seen_inval, cache_dirty_writeback}), 36'h2);
            check_val(36'(seen_early), 36'h0);
            @(posedge clk);
            bus_drive_req <= drv;
            repeat (3) @(posedge clk);
            #1 check_val(36'(bus_out_en), 36'(drv && !exp_float(cfg)));
        end
    endtask

    initial begin
        reset_n = 1'b0; start = 1'b0; early = 1'b0; soft_init_n = 1'b1;
        bus_drive_req = 1'b0; cfg_strap = 8'h00; errors = 0; comparisons = 0;
        void'($urandom(9238));
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        boot(8'h00, 1'b1, 1'b0);
        boot(8'h00, 1'b0, 1'b0);
        boot(8'h01, 1'b0, 1'b0);
        boot(8'hFE, 1'b1, 1'b1);
        for (int i = 0; i < 6; i++) begin
            boot(8'($urandom), 1'($urandom), 1'($urandom));
        end
        // chip reset in mid-run clears every state output
        @(posedge clk);
        reset_n <= 1'b0;
        @(posedge clk);
        #1 check_val(36'({bus_out_en, core_running, outputs_float, self_test_run,
                          fetch_valid, cache_inval_busy}), 36'h0);
        @(posedge clk);
        reset_n <= 1'b1;
        boot(8'h5A, 1'b0, 1'b0);
        finish_test();
    end
endmodule
